// ===== hw/calib_trim_pkg.sv
// Constants and types for the calibration vector port and trim register bank
// Notes on behaviour
// RL1 - The vector data register works only while bit 0 of the port enable register is set.
// RL2 - Each read of the data register with access enabled returns the next vector byte, 673 in all.
// RL3 - Each write of the data register with access enabled loads the next vector byte, 673 in all.
// RL4 - The host should hold the address and stream the 673 accesses to make them faster.
// RL5 - The host must not touch the data register while the calibration halted flag is 0.
// RL6 - The host must finish all 673 accesses, or the stored calibration becomes invalid.
// RL7 - The input A gain adjust register holds the fused value after reset and is read/write.
// RL8 - The input B gain adjust register holds the fused value after reset and is read/write.
// RL9 - The reference voltage adjust is a 4-bit field in bits 3:0 with bits 7:4 reserved.
// RL10 - The input A termination adjust register holds the fused value after reset and is read/write.
// RL11 - The input B termination adjust register holds the fused value after reset and is read/write.
// RL12 - A vector index returns to byte 0 on enable and advances by one per data access; here it stops at byte 672, the last, and holds there.
package calib_trim_pkg;

   localparam int          VECTOR_BYTES   = 673;
   localparam int          INDEX_WIDTH    = 10;
   localparam logic [7:0]  OFS_PORT_EN    = 8'h70;
   localparam logic [7:0]  OFS_VEC_BYTE   = 8'h71;
   localparam logic [7:0]  OFS_GAIN_A     = 8'h7A;
   localparam logic [7:0]  OFS_GAIN_B     = 8'h7B;
   localparam logic [7:0]  OFS_REF_ADJ    = 8'h7C;
   localparam logic [7:0]  OFS_TERM_A     = 8'h7E;
   localparam logic [7:0]  OFS_TERM_B     = 8'h7F;
   localparam logic [7:0]  RESET_PORT_EN  = 8'h00;
   localparam logic [7:0]  RESET_TRIM     = 8'h00;
   localparam int          PORT_EN_BIT    = 0;
   localparam logic [7:0]  REF_ADJ_MASK   = 8'h0F;

   // One register port access
   typedef struct packed {
      logic       read;
      logic       write;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_access_type;

   // Factory fuse values for the trim registers
   typedef struct packed {
      logic [7:0] gain_a;
      logic [7:0] gain_b;
      logic [3:0] ref_adj;
      logic [7:0] term_a;
      logic [7:0] term_b;
   } fuse_trim_type;

endpackage

// ===== hw/calib_vector_and_trim_regs.sv
// Calibration vector save/restore port and fuse-loaded trim registers
`timescale 1ns/10ps
`default_nettype none
module calib_vector_and_trim_regs #(
   parameter int VECTOR_BYTES = calib_trim_pkg::VECTOR_BYTES
) (
   // Clock and reset
   input  wire logic                          MCLK_IN,
   input  wire logic                          RST_IN,
   // Register port, same clock domain
   input  wire calib_trim_pkg::reg_access_type ACCESS_IN,
   output logic      [7:0]                    RDATA_OUT,
   // Factory fuses, static, sampled at reset
   input  wire calib_trim_pkg::fuse_trim_type FUSE_IN,
   // Calibration engine state
   input  wire logic                          CALIBRATION_HALTED_FLAG_IN,
   // Trim values to the analog blocks, plus port enable, vector index and misuse status
   output calib_trim_pkg::fuse_trim_type      TRIM_OUT,
   output logic                               PORT_ENABLED_OUT,
   output logic [calib_trim_pkg::INDEX_WIDTH-1:0] VECTOR_INDEX_OUT,
   output logic                               ACCESS_VIOLATION_OUT
);

   localparam int IW = calib_trim_pkg::INDEX_WIDTH;

   logic [7:0]    port_enable;
   logic [IW-1:0] index;
   logic [7:0]    store_rdata;
   logic          halted_meta;
   logic          halted_sync;
   calib_trim_pkg::fuse_trim_type trim;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      return a == ofs;
   endfunction

   wire logic wr        = ACCESS_IN.write;
   wire logic rd        = ACCESS_IN.read;
   wire logic [7:0] adr = ACCESS_IN.addr;
   wire logic [7:0] wd  = ACCESS_IN.wdata;

   // RL1 enable gates port
   wire logic port_on   = port_enable[calib_trim_pkg::PORT_EN_BIT];
   wire logic vec_acc   = port_on && (rd || wr) && hit(adr, calib_trim_pkg::OFS_VEC_BYTE);
   wire logic vec_wr    = vec_acc && wr;
   wire logic en_write  = wr && hit(adr, calib_trim_pkg::OFS_PORT_EN);
   wire logic en_rise   = en_write && wd[calib_trim_pkg::PORT_EN_BIT] && !port_on;
   // Enable flag shown with the register it mirrors, not a cycle behind it
   wire logic next_port_on = en_write ? wd[calib_trim_pkg::PORT_EN_BIT] : port_on;
   // RL12 index advance
   wire logic [IW-1:0] next_index =
      en_rise ? '0 :
      (vec_acc && (int'(index) < VECTOR_BYTES - 1)) ? index + IW'(1) : index;

   calib_vector_store #(
      .DEPTH       (VECTOR_BYTES),
      .INDEX_WIDTH (IW)
   ) u_store (
      .clk_in    (MCLK_IN),
      .rst_in    (RST_IN),
      .wr_en_in  (vec_wr),
      .index_in  (index),
      .wdata_in  (wd),
      .rdata_out (store_rdata)
   );

   // Read mux; the vector byte reads zero while the port is off
   logic [7:0] next_rdata;
   always_comb begin
      next_rdata = 8'h00;
      unique case (adr)
         calib_trim_pkg::OFS_PORT_EN:  next_rdata = port_enable;
         // RL2 read next byte
         calib_trim_pkg::OFS_VEC_BYTE: next_rdata = port_on ? store_rdata : 8'h00;
         calib_trim_pkg::OFS_GAIN_A:   next_rdata = trim.gain_a;
         calib_trim_pkg::OFS_GAIN_B:   next_rdata = trim.gain_b;
         calib_trim_pkg::OFS_REF_ADJ:  next_rdata = {4'h0, trim.ref_adj};
         calib_trim_pkg::OFS_TERM_A:   next_rdata = trim.term_a;
         calib_trim_pkg::OFS_TERM_B:   next_rdata = trim.term_b;
         default:                      next_rdata = 8'h00;
      endcase
   end

   // Halted flag comes from another block, resynchronised
   always_ff @(posedge MCLK_IN) begin
      halted_meta <= CALIBRATION_HALTED_FLAG_IN;
      halted_sync <= halted_meta;
   end

   always_ff @(posedge MCLK_IN) begin
      if (RST_IN) begin
         port_enable <= calib_trim_pkg::RESET_PORT_EN;
         index       <= '0;
      end else begin
         if (en_write) begin
            port_enable <= wd;
         end
         // RL3 write next byte
         index <= next_index;
      end
   end

   // RL7 RL8 fuse load
   // Fuses are static, so a clocked load during reset is safe
   always_ff @(posedge MCLK_IN) begin
      if (RST_IN) begin
         trim <= FUSE_IN;
      end else begin
         if (wr && hit(adr, calib_trim_pkg::OFS_GAIN_A)) trim.gain_a <= wd;
         if (wr && hit(adr, calib_trim_pkg::OFS_GAIN_B)) trim.gain_b <= wd;
         // RL9 low nibble only
         if (wr && hit(adr, calib_trim_pkg::OFS_REF_ADJ)) trim.ref_adj <= wd[3:0];
         // RL10 RL11 termination
         if (wr && hit(adr, calib_trim_pkg::OFS_TERM_A)) trim.term_a <= wd;
         if (wr && hit(adr, calib_trim_pkg::OFS_TERM_B)) trim.term_b <= wd;
      end
   end

   always_ff @(posedge MCLK_IN) begin
      if (RST_IN) begin
         RDATA_OUT            <= 8'h00;
         // RL7 RL8 fused trims show from the first cycle after reset
         TRIM_OUT             <= FUSE_IN;
         PORT_ENABLED_OUT     <= 1'b0;
         VECTOR_INDEX_OUT     <= '0;
         ACCESS_VIOLATION_OUT <= 1'b0;
      end else begin
         if (rd) RDATA_OUT <= next_rdata;
         TRIM_OUT         <= trim;
         PORT_ENABLED_OUT <= next_port_on;
         VECTOR_INDEX_OUT <= next_index;
         // RL5 flags misuse; sticky until port re-enabled
         if (vec_acc && !halted_sync) ACCESS_VIOLATION_OUT <= 1'b1;
         else if (en_rise) ACCESS_VIOLATION_OUT <= 1'b0;
      end
   end

endmodule // calib_vector_and_trim_regs
`default_nettype wire

// ===== hw/calib_vector_store.sv
// Byte store that holds the calibration vector, read and written by index
`timescale 1ns/10ps
`default_nettype none
module calib_vector_store #(
   parameter int DEPTH       = calib_trim_pkg::VECTOR_BYTES,
   parameter int INDEX_WIDTH = calib_trim_pkg::INDEX_WIDTH
) (
   // Clock and reset
   input  wire logic                   clk_in,
   input  wire logic                   rst_in,
   // Access
   input  wire logic                   wr_en_in,
   input  wire logic [INDEX_WIDTH-1:0] index_in,
   input  wire logic [7:0]             wdata_in,
   output logic      [7:0]             rdata_out
);

   logic [7:0] mem [DEPTH];

   // Out-of-range index reads zero rather than wrapping
   assign rdata_out = (int'(index_in) < DEPTH) ? mem[index_in] : 8'h00;

   genvar g;
   generate
      for (g = 0; g < DEPTH; g++) begin : g_byte
         always_ff @(posedge clk_in) begin
            if (rst_in) begin
               mem[g] <= 8'h00;
            end else if (wr_en_in && (int'(index_in) == g)) begin
               mem[g] <= wdata_in;
            end
         end
      end
   endgenerate

endmodule // calib_vector_store
`default_nettype wire

// ===== verification/calib_vector_and_trim_regs_chk.sv
// Concurrent checks on the calibration port and trim bank
`timescale 1ns/10ps
`default_nettype none
module calib_vector_and_trim_regs_chk #(
   parameter int VECTOR_BYTES = calib_trim_pkg::VECTOR_BYTES
) (
   // Watched ports
   input wire logic                           MCLK_IN,
   input wire logic                           RST_IN,
   input wire calib_trim_pkg::reg_access_type ACCESS_IN,
   input wire logic [7:0]                     RDATA_OUT,
   input wire calib_trim_pkg::fuse_trim_type  FUSE_IN,
   input wire calib_trim_pkg::fuse_trim_type  TRIM_OUT,
   input wire logic                           PORT_ENABLED_OUT,
   input wire logic [9:0]                     VECTOR_INDEX_OUT
);
   wire logic       wr = ACCESS_IN.write;
   wire logic [7:0] ad = ACCESS_IN.addr;
   wire logic       dp = (ACCESS_IN.read || wr) && ad == 8'h71;
   default clocking @(posedge MCLK_IN); endclocking
   default disable iff (RST_IN);
   gate_read_a: assert property (dp && ACCESS_IN.read && !PORT_ENABLED_OUT
      |=> RDATA_OUT == 8'h00) else $error("disabled port read not zero");
   gate_index_a: assert property (dp && !PORT_ENABLED_OUT
      |=> $stable(VECTOR_INDEX_OUT)) else $error("disabled port moved index");
   index_step_a: assert property (dp && PORT_ENABLED_OUT && VECTOR_INDEX_OUT < VECTOR_BYTES - 1
      |=> VECTOR_INDEX_OUT == $past(VECTOR_INDEX_OUT) + 1'b1) else $error("index not advanced");
   index_clear_a: assert property (wr && ad == 8'h70 && ACCESS_IN.wdata[0] && !PORT_ENABLED_OUT
      |=> VECTOR_INDEX_OUT == 10'h000) else $error("index not cleared on enable");
   trim_reset_a: assert property ($fell(RST_IN)
      |-> TRIM_OUT == FUSE_IN) else $error("trims not fused after reset");
   ref_reserved_a: assert property (ACCESS_IN.read && ad == 8'h7C
      |=> RDATA_OUT[7:4] == 4'h0) else $error("reserved reference bits set");
   gain_write_a: assert property (wr && ad == 8'h7A
      |-> ##2 TRIM_OUT.gain_a == $past(ACCESS_IN.wdata, 2)) else $error("gain A not written");
   term_write_a: assert property (wr && ad == 8'h7F
      |-> ##2 TRIM_OUT.term_b == $past(ACCESS_IN.wdata, 2)) else $error("term B not written");
endmodule // calib_vector_and_trim_regs_chk
bind calib_vector_and_trim_regs calib_vector_and_trim_regs_chk #(.VECTOR_BYTES(VECTOR_BYTES))
   u_calib_vector_and_trim_regs_chk (.MCLK_IN(MCLK_IN), .RST_IN(RST_IN), .ACCESS_IN(ACCESS_IN),
   .RDATA_OUT(RDATA_OUT), .FUSE_IN(FUSE_IN), .TRIM_OUT(TRIM_OUT),
   .PORT_ENABLED_OUT(PORT_ENABLED_OUT), .VECTOR_INDEX_OUT(VECTOR_INDEX_OUT));
`default_nettype wire

// ===== verification/calib_vector_and_trim_regs_tb.sv
// Self-checking bench for the calibration port and trim bank
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin miscompares++; \
   $display("MISMATCH t=%0t got %h exp %h", $time, a, e); end end
module calib_vector_and_trim_regs_tb;
   localparam int vec_len = calib_trim_pkg::VECTOR_BYTES;
   logic mclk_in = 1'b0;
   logic rst_in = 1'b1;
   logic [7:0] rdata, q, d;
   logic [9:0] idx;
   logic [7:0] vec [vec_len];
   logic [7:0] ofs [7] = '{8'h7A, 8'h7B, 8'h7C, 8'h7E, 8'h7F, 8'h75, 8'h7D};
   calib_trim_pkg::reg_access_type acc;
   calib_trim_pkg::fuse_trim_type fuse;
   logic halted;
   logic viol;
   int seed = 32'h0031;
   int miscompares = 0;
   int samples_checked = 0;
   always #5 mclk_in = ~mclk_in;
   host_port_model u_host_port_model (.clk_in(mclk_in), .rdata_in(rdata),
      .access_out(acc), .halted_out(halted));
   calib_vector_and_trim_regs u_calib_vector_and_trim_regs (.MCLK_IN(mclk_in), .RST_IN(rst_in),
      .ACCESS_IN(acc), .RDATA_OUT(rdata), .FUSE_IN(fuse), .CALIBRATION_HALTED_FLAG_IN(halted),
      .TRIM_OUT(), .PORT_ENABLED_OUT(), .VECTOR_INDEX_OUT(idx), .ACCESS_VIOLATION_OUT(viol));
   // Unmapped places read zero
   function automatic logic [7:0] expect_of(input logic [7:0] a, dv, input logic w);
      logic [7:0] v;
      case (a)
         8'h7A: v = fuse.gain_a;
         8'h7B: v = fuse.gain_b;
         8'h7C: v = {4'h0, fuse.ref_adj};
         8'h7E: v = fuse.term_a;
         8'h7F: v = fuse.term_b;
         default: return 8'h00;
      endcase
      if (w) v = dv;
      return (a == 8'h7C) ? (v & 8'h0F) : v;
   endfunction
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge mclk_in);
      miscompares++;
      tally_and_finish();
   end
   initial begin
      fuse = calib_trim_pkg::fuse_trim_type'(36'({$random(seed), $random(seed)}));
      repeat (8) @(negedge mclk_in);
      rst_in = 1'b0;
      u_host_port_model.set_halted(1'b1);
      foreach (ofs[i]) begin
         u_host_port_model.xfer(1'b1, 1'b0, ofs[i], 8'h00, q);
         `CHK(q, expect_of(ofs[i], 8'h00, 1'b0))
         d = $random(seed);
         u_host_port_model.xfer(1'b0, 1'b1, ofs[i], d, q);
         u_host_port_model.xfer(1'b1, 1'b0, ofs[i], 8'h00, q);
         `CHK(q, expect_of(ofs[i], d, 1'b1))
      end
      u_host_port_model.xfer(1'b0, 1'b1, 8'h71, 8'hA5, q);
      u_host_port_model.xfer(1'b1, 1'b0, 8'h71, 8'h00, q);
      `CHK(q, 8'h00)
      u_host_port_model.xfer(1'b0, 1'b1, 8'h70, 8'h01, q);
      for (int i = 0; i < vec_len; i++) begin
         vec[i] = $random(seed);
         u_host_port_model.xfer(1'b0, 1'b1, 8'h71, vec[i], q);
      end
      u_host_port_model.xfer(1'b0, 1'b1, 8'h70, 8'h00, q);
      u_host_port_model.xfer(1'b0, 1'b1, 8'h70, 8'h01, q);
      `CHK(idx, 10'h000)
      for (int i = 0; i < vec_len; i++) begin
         u_host_port_model.xfer(1'b1, 1'b0, 8'h71, 8'h00, q);
         `CHK(q, vec[i])
      end
      u_host_port_model.xfer(1'b0, 1'b0, 8'h00, 8'h00, q);
      `CHK(viol, 1'b0)
      u_host_port_model.set_halted(1'b0);
      u_host_port_model.xfer(1'b0, 1'b0, 8'h00, 8'h00, q);
      u_host_port_model.xfer(1'b0, 1'b0, 8'h00, 8'h00, q);
      u_host_port_model.xfer(1'b1, 1'b0, 8'h71, 8'h00, q);
      `CHK(viol, 1'b1)
      u_host_port_model.xfer(1'b0, 1'b0, 8'h00, 8'h00, q);
      tally_and_finish();
   end
endmodule // calib_vector_and_trim_regs_tb
`default_nettype wire

// ===== verification/host_port_model.sv
// Host controller model on the register port
`timescale 1ns/10ps
`default_nettype none
module host_port_model (
   // Clock and answer
   input  wire logic                      clk_in,
   input  wire logic [7:0]                rdata_in,
   // Requests and halted flag
   output calib_trim_pkg::reg_access_type access_out,
   output logic                           halted_out
);
   initial access_out = '0;
   initial halted_out = 1'b0;
   // calibration engine state seen by the device
   task automatic set_halted(input logic h);
      halted_out = h;
   endtask
   task automatic xfer(input logic r, w, input logic [7:0] a, d, output logic [7:0] q);
      access_out <= '{r, w, a, d};
      @(negedge clk_in);
      q = rdata_in;
   endtask
endmodule // host_port_model
`default_nettype wire
